// File: rtl/cts_pkg.sv
// Constants, types and register map of the compare, test-skip and memory-add unit.
// Assumes one core clock; shared by every design file of the unit.
package cts_pkg;

  // ************************************************
  // Sizes
  // ************************************************
  localparam int NUM_REGS = 8;
  localparam int REG_W = 8;
  localparam int MEM_ADDR_W = 16;

  // ************************************************
  // Register byte offsets
  // ************************************************
  localparam logic [7:0] OFS_GPR_BASE = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h20;
  localparam logic [7:0] OFS_INSTR = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // ************************************************
  // Register indexes and reset values
  // ************************************************
  localparam logic [2:0] IDX_V = 3'h0;
  localparam logic [2:0] IDX_A = 3'h1;
  localparam logic [2:0] IDX_B = 3'h2;
  localparam logic [2:0] IDX_C = 3'h3;
  localparam logic [2:0] IDX_D = 3'h4;
  localparam logic [2:0] IDX_E = 3'h5;
  localparam logic [2:0] IDX_H = 3'h6;
  localparam logic [2:0] IDX_L = 3'h7;
  localparam logic [7:0] GPR_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ************************************************
  // Flag and status bit positions
  // ************************************************
  localparam int FLG_Z = 6;
  localparam int FLG_SK = 5;
  localparam int FLG_HC = 4;
  localparam int FLG_L1 = 3;
  localparam int FLG_L0 = 2;
  localparam int FLG_CY = 0;
  localparam int STS_BUSY = 0;
  localparam int STS_ILLEGAL = 1;
  localparam int STS_DISCARD = 2;

  // ************************************************
  // Encodings
  // ************************************************
  localparam logic [7:0] PREFIX_REG = 8'h60;
  localparam logic [7:0] PREFIX_MEM = 8'h70;
  localparam logic [4:0] OPC_NE_AR = 5'h1d;
  localparam logic [4:0] OPC_NE_RA = 5'h0d;
  localparam logic [4:0] OPC_EQ_AR = 5'h1f;
  localparam logic [4:0] OPC_EQ_RA = 5'h0f;
  localparam logic [4:0] OPC_ON = 5'h19;
  localparam logic [4:0] OPC_OFF = 5'h1b;
  localparam logic [4:0] OPC_ADDM = 5'h18;
  localparam logic [2:0] PAIR_BC = 3'h1;
  localparam logic [2:0] PAIR_DE = 3'h2;
  localparam logic [2:0] PAIR_HL = 3'h3;
  localparam logic [2:0] PAIR_DE_INC = 3'h4;
  localparam logic [2:0] PAIR_HL_INC = 3'h5;
  localparam logic [2:0] PAIR_DE_DEC = 3'h6;
  localparam logic [2:0] PAIR_HL_DEC = 3'h7;

  // ************************************************
  // Cycle counts
  // ************************************************
  localparam logic [3:0] STATES_REG = 4'h8;
  localparam logic [3:0] STATES_MEM = 4'hb;
  localparam logic [3:0] MEM_CAPTURE_CNT = 4'h1;

  typedef enum {OP_NONE, OP_NE, OP_EQ, OP_ON, OP_OFF, OP_ADDM} cts_op_type;
  typedef enum {ST_IDLE, ST_EXEC} cts_state_type;

endpackage

// File: rtl/cts_core_if.sv
// Signals between the control, the arithmetic unit and the register file.
// Assumes all three parts run on the same clock.
`timescale 1ns/100ps
interface cts_core_if
  import cts_pkg::*;
  ();
  cts_op_type alu_op;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_z;
  logic alu_hc;
  logic alu_cy;
  logic [NUM_REGS-1:0][7:0] rf_regs;
  logic sw_we;
  logic [2:0] sw_idx;
  logic [7:0] sw_data;
  logic [NUM_REGS-1:0] ex_we;
  logic [NUM_REGS-1:0][7:0] ex_data;

  modport alu (input alu_op, alu_a, alu_b, output alu_res, alu_z, alu_hc, alu_cy);
  modport rf (input sw_we, sw_idx, sw_data, ex_we, ex_data, output rf_regs);
  modport ctl (output alu_op, alu_a, alu_b, sw_we, sw_idx, sw_data, ex_we, ex_data,
    input alu_res, alu_z, alu_hc, alu_cy, rf_regs);
endinterface

// File: rtl/cts_alu.sv
// Combinational subtract, AND and add with zero, half-carry and carry results.
// Assumes operands are ordered first, second by the control.
`timescale 1ns/100ps
module cts_alu
  import cts_pkg::*;
(
  // Core signals
  cts_core_if.alu bus
);
  logic [8:0] wide;
  logic [4:0] nib;

  always_comb
  begin
    wide = 9'h000;
    nib = 5'h00;
    bus.alu_res = 8'h00;
    bus.alu_hc = 1'b0;
    bus.alu_cy = 1'b0;
    case (bus.alu_op)
      OP_NE, OP_EQ:
      begin
        wide = {1'b0, bus.alu_a} - {1'b0, bus.alu_b};
        nib = {1'b0, bus.alu_a[3:0]} - {1'b0, bus.alu_b[3:0]};
        bus.alu_res = wide[7:0];
        bus.alu_cy = wide[8];
        bus.alu_hc = nib[4];
      end
      OP_ON, OP_OFF:
        bus.alu_res = bus.alu_a & bus.alu_b;
      OP_ADDM:
      begin
        wide = {1'b0, bus.alu_a} + {1'b0, bus.alu_b};
        nib = {1'b0, bus.alu_a[3:0]} + {1'b0, bus.alu_b[3:0]};
        bus.alu_res = wide[7:0];
        bus.alu_cy = wide[8];
        bus.alu_hc = nib[4];
      end
      default:
        bus.alu_res = 8'h00;
    endcase
    bus.alu_z = (bus.alu_res == 8'h00);
  end
endmodule

// File: rtl/cts_regfile.sv
// Eight byte registers with one software write port and per-register execute writes.
// Assumes software and execute writes never hit the same cycle.
`timescale 1ns/100ps
module cts_regfile
  import cts_pkg::*;
#(
  parameter int NUM = NUM_REGS
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Core signals
  cts_core_if.rf bus
);
  if (NUM != 8)
  begin : g_num_check
    $error("Register file needs exactly eight registers");
  end

  for (genvar i = 0; i < NUM; i++)
  begin : g_reg
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        bus.rf_regs[i] <= GPR_RESET;
      else if (ce)
      begin
        if (bus.ex_we[i])
          bus.rf_regs[i] <= bus.ex_data[i];
        else if (bus.sw_we && bus.sw_idx == 3'(i))
          bus.rf_regs[i] <= bus.sw_data;
      end
    end
  end
endmodule

// File: rtl/cts_unit.sv
// Compare-skip, AND-test-skip and memory-add execution unit with an AHB-Lite register port.
// Assumes a single-cycle-latency byte memory on the same clock and word-only bus transfers.
`timescale 1ns/100ps
module cts_unit
  import cts_pkg::*;
(
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Data memory read port
  output logic [MEM_ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata
);
  cts_core_if core ();

  cts_alu u_alu (
    .bus(core.alu)
  );

  cts_regfile #(.NUM(NUM_REGS)) u_rf (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .bus(core.rf)
  );

  // ************************************************
  // Decoding
  // ************************************************
  function automatic cts_op_type decode(input logic [15:0] w);
    cts_op_type op;
    op = OP_NONE;
    if (w[15:8] == PREFIX_REG)
    begin
      case (w[7:3])
        OPC_NE_AR, OPC_NE_RA: op = OP_NE;
        OPC_EQ_AR, OPC_EQ_RA: op = OP_EQ;
        OPC_ON: op = OP_ON;
        OPC_OFF: op = OP_OFF;
        default: op = OP_NONE;
      endcase
    end
    else if (w[15:8] == PREFIX_MEM && w[7:3] == OPC_ADDM && w[2:0] != 3'h0)
      op = OP_ADDM;
    return op;
  endfunction

  function automatic logic [15:0] pair_of(input logic [2:0] sel, input logic [NUM_REGS-1:0][7:0] r);
    logic [15:0] p;
    case (sel)
      PAIR_BC: p = {r[IDX_B], r[IDX_C]};
      PAIR_DE, PAIR_DE_INC, PAIR_DE_DEC: p = {r[IDX_D], r[IDX_E]};
      PAIR_HL, PAIR_HL_INC, PAIR_HL_DEC: p = {r[IDX_H], r[IDX_L]};
      default: p = 16'h0000;
    endcase
    return p;
  endfunction

  // ************************************************
  // Bus address phase
  // ************************************************
  logic ap_valid;
  logic ap_write;
  logic [7:0] ap_addr;
  logic [7:0] flags;
  logic [7:0] status;
  cts_state_type state;
  logic [3:0] cnt;
  cts_op_type op_q;
  logic swap_q;
  logic [2:0] rsel_q;
  logic [2:0] psel_q;
  logic [7:0] mem_data_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end
    else if (ce && hready)
    begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  function automatic logic [31:0] read_reg(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a < OFS_FLAGS && a[1:0] == 2'h0)
      d = {24'h000000, core.rf_regs[a[4:2]]};
    else if (a == OFS_FLAGS)
      d = {24'h000000, flags};
    else if (a == OFS_STATUS)
      d = {24'h000000, status};
    return d;
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ce && hready && hsel && htrans[1] && !hwrite)
      hrdata <= read_reg(haddr[7:0]);
  end

  // ************************************************
  // Write data phase
  // ************************************************
  logic wr;
  logic idle;
  logic start;
  logic discard;
  logic commit;
  logic [3:0] last_cnt;
  cts_op_type dec;

  assign wr = ap_valid && ap_write;
  assign idle = (state == ST_IDLE);
  assign dec = decode(hwdata[15:0]);
  assign discard = wr && ap_addr == OFS_INSTR && idle && flags[FLG_SK];
  assign start = wr && ap_addr == OFS_INSTR && idle && !flags[FLG_SK] && dec != OP_NONE;
  assign last_cnt = (op_q == OP_ADDM) ? STATES_MEM - 4'h1 : STATES_REG - 4'h1;
  assign commit = (state == ST_EXEC) && (cnt == last_cnt);

  assign core.sw_we = wr && idle && ap_addr < OFS_FLAGS && ap_addr[1:0] == 2'h0;
  assign core.sw_idx = ap_addr[4:2];
  assign core.sw_data = hwdata[7:0];

  // ************************************************
  // Execution sequence
  // ************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      op_q <= OP_NONE;
      swap_q <= 1'b0;
      rsel_q <= 3'h0;
      psel_q <= 3'h0;
    end
    else if (ce)
    begin
      if (start)
      begin
        state <= ST_EXEC;
        cnt <= 4'h0;
        op_q <= dec;
        swap_q <= ~hwdata[7];
        rsel_q <= hwdata[2:0];
        psel_q <= hwdata[2:0];
      end
      else if (commit)
        state <= ST_IDLE;
      else if (state == ST_EXEC)
        cnt <= cnt + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_rd <= 1'b0;
      mem_addr <= '0;
      mem_data_q <= 8'h00;
    end
    else if (ce)
    begin
      mem_rd <= start && dec == OP_ADDM;
      if (start && dec == OP_ADDM)
        mem_addr <= pair_of(hwdata[2:0], core.rf_regs);
      if (state == ST_EXEC && op_q == OP_ADDM && cnt == MEM_CAPTURE_CNT)
        mem_data_q <= mem_rdata;
    end
  end

  // ************************************************
  // Operands and result write-back
  // ************************************************
  logic [7:0] acc;
  logic [7:0] sel_reg;
  logic [15:0] pair_now;
  logic [15:0] pair_next;

  assign acc = core.rf_regs[IDX_A];
  assign sel_reg = core.rf_regs[rsel_q];
  assign pair_now = pair_of(psel_q, core.rf_regs);
  assign core.alu_op = op_q;

  always_comb
  begin
    core.alu_a = acc;
    core.alu_b = sel_reg;
    if (op_q == OP_ADDM)
      core.alu_b = mem_data_q;
    else if ((op_q == OP_NE || op_q == OP_EQ) && swap_q)
    begin
      core.alu_a = sel_reg;
      core.alu_b = acc;
    end
  end

  always_comb
  begin
    pair_next = pair_now;
    if (psel_q == PAIR_DE_INC || psel_q == PAIR_HL_INC)
      pair_next = pair_now + 16'h0001;
    else if (psel_q == PAIR_DE_DEC || psel_q == PAIR_HL_DEC)
      pair_next = pair_now - 16'h0001;
  end

  always_comb
  begin
    core.ex_we = '0;
    core.ex_data = core.rf_regs;
    if (commit && op_q == OP_ADDM)
    begin
      core.ex_we[IDX_A] = 1'b1;
      core.ex_data[IDX_A] = core.alu_res;
      if (psel_q[2])
      begin
        if (psel_q[0])
        begin
          core.ex_we[IDX_H] = 1'b1;
          core.ex_we[IDX_L] = 1'b1;
          core.ex_data[IDX_H] = pair_next[15:8];
          core.ex_data[IDX_L] = pair_next[7:0];
        end
        else
        begin
          core.ex_we[IDX_D] = 1'b1;
          core.ex_we[IDX_E] = 1'b1;
          core.ex_data[IDX_D] = pair_next[15:8];
          core.ex_data[IDX_E] = pair_next[7:0];
        end
      end
    end
  end

  // ************************************************
  // Flags and status
  // ************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags <= FLAGS_RESET;
    else if (ce)
    begin
      if (discard)
        flags[FLG_SK] <= 1'b0;
      else if (wr && idle && ap_addr == OFS_FLAGS)
        flags <= hwdata[7:0];
      else if (commit)
      begin
        flags[FLG_L1] <= 1'b0;
        flags[FLG_L0] <= 1'b0;
        flags[FLG_Z] <= core.alu_z;
        case (op_q)
          OP_NE, OP_EQ:
          begin
            flags[FLG_HC] <= core.alu_hc;
            flags[FLG_CY] <= core.alu_cy;
            flags[FLG_SK] <= (op_q == OP_NE) ? !core.alu_z : core.alu_z;
          end
          OP_ON:
            flags[FLG_SK] <= !core.alu_z;
          OP_OFF:
            flags[FLG_SK] <= core.alu_z;
          OP_ADDM:
          begin
            flags[FLG_HC] <= core.alu_hc;
            flags[FLG_CY] <= core.alu_cy;
            flags[FLG_SK] <= 1'b0;
          end
          default:
            flags[FLG_SK] <= flags[FLG_SK];
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status <= 8'h00;
    else if (ce)
    begin
      status[STS_BUSY] <= start || (state == ST_EXEC && !commit);
      if (wr && ap_addr == OFS_INSTR && idle)
      begin
        status[STS_DISCARD] <= discard;
        status[STS_ILLEGAL] <= !discard && dec == OP_NONE;
      end
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  logic [7:0] cmp_a_h;
  logic [7:0] cmp_b_h;
  assign cmp_a_h = core.alu_a;
  assign cmp_b_h = core.alu_b;

  a_reg_state_count: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    start && dec != OP_ADDM |=> (state == ST_EXEC) [*8] ##1 (state == ST_IDLE))
    else $error("Register form did not take eight cycles");

  a_ne_skip: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && op_q == OP_NE |=> flags[FLG_SK] == ($past(cmp_a_h) != $past(cmp_b_h)))
    else $error("Not-equal skip wrong");

  a_eq_skip: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && op_q == OP_EQ |=> flags[FLG_SK] == ($past(cmp_a_h) == $past(cmp_b_h)))
    else $error("Equal skip wrong");

  a_cmp_carry_zero: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && (op_q == OP_NE || op_q == OP_EQ) |=>
    flags[FLG_CY] == ($past(cmp_a_h) < $past(cmp_b_h)) && flags[FLG_Z] == ($past(cmp_a_h) == $past(cmp_b_h)))
    else $error("Compare carry or zero wrong");

  a_load_flags_clear: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit |=> !flags[FLG_L1] && !flags[FLG_L0])
    else $error("Consecutive-load flags not cleared");

  a_on_test_skip: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && op_q == OP_ON |=> flags[FLG_SK] == (($past(acc) & $past(sel_reg)) != 8'h00))
    else $error("On-test skip wrong");

  a_off_test_skip: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && op_q == OP_OFF |=> flags[FLG_SK] == (($past(acc) & $past(sel_reg)) == 8'h00))
    else $error("Off-test skip wrong");

  a_test_keeps_carry: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && (op_q == OP_ON || op_q == OP_OFF) |=>
    flags[FLG_CY] == $past(flags[FLG_CY]) && flags[FLG_HC] == $past(flags[FLG_HC]))
    else $error("Test changed carry or half-carry");

  a_add_acc_result: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && op_q == OP_ADDM |=> acc == 8'($past(acc) + $past(mem_data_q)) && !flags[FLG_SK])
    else $error("Memory add result or skip wrong");

  a_mem_addr_pair: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    start && dec == OP_ADDM |=> mem_rd && mem_addr == pair_of(psel_q, core.rf_regs))
    else $error("Memory address is not the pair");

  a_pair_post_step: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    commit && op_q == OP_ADDM && psel_q[2] |=>
    pair_of(psel_q, core.rf_regs) == ($past(psel_q[1]) ? $past(pair_now) - 16'h0001 : $past(pair_now) + 16'h0001))
    else $error("Pair not stepped after use");

  a_discard_next: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    discard |=> state == ST_IDLE && !flags[FLG_SK] && status[STS_DISCARD])
    else $error("Skipped instruction was not discarded");

  c_ne_skip: cover property (@(posedge hclk) commit && op_q == OP_NE && !core.alu_z);
  c_off_skip: cover property (@(posedge hclk) commit && op_q == OP_OFF && core.alu_z);
  c_add_dec: cover property (@(posedge hclk) commit && op_q == OP_ADDM && psel_q == PAIR_HL_DEC);
  c_discard: cover property (@(posedge hclk) discard);
endmodule

// File: dv/tb.sv
// Self-checking bench for the compare, test-skip and memory-add unit.
// Assumes zero-wait AHB-Lite answers and a one-cycle byte memory driven here.
`timescale 1ns/100ps
module tb;
  // Clock, reset and bus
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // Memory port
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] rm [8];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int rd_pulses = 0;

  assign hready = hreadyout;

  cts_unit u_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(1'b1),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_rdata(mem_rdata)
  );

  always #20 hclk = ~hclk;

  // ****************************************
  // Memory model and run limit
  // ****************************************
  function automatic logic [7:0] mem_f(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  always @(posedge hclk)
  begin
    if (mem_rd === 1'b1)
    begin
      mem_rdata <= mem_f(mem_addr);
      rd_pulses++;
    end
    else
      mem_rdata <= ~mem_rdata;
  end

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hready !== 1'b1);
    chk(hrdata, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic run(input logic [15:0] ins, input int states);
    wr(32'h24, {16'h0, ins});
    repeat (states - 2) @(posedge hclk);
    rd_chk(32'h28, 32'h1);
    rd_chk(32'h28, 32'h0);
  endtask

  function automatic logic [7:0] exp_flags(input int op, input logic [7:0] a, input logic [7:0] r,
    input logic [7:0] old);
    logic [7:0] s;
    logic [7:0] t;
    logic [7:0] p;
    s = (op == 1 || op == 3) ? r : a;
    t = (op == 1 || op == 3) ? a : r;
    p = a & r;
    if (op < 4)
      return {old[7], s == t, (op < 2) ? s != t : s == t, s[3:0] < t[3:0], 2'b00, old[1], s < t};
    return {old[7], p == 8'h00, (op == 4) ? p != 8'h00 : p == 8'h00, old[4], 2'b00, old[1], old[0]};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int op;
    int r;
    int s;
    int sel;
    logic [7:0] fl;
    logic [7:0] v;
    logic [8:0] sum;
    logic [4:0] nb;
    logic [15:0] pr;
    logic [4:0] opc [6];
    opc = '{5'h1d, 5'h0d, 5'h1f, 5'h0f, 5'h19, 5'h1b};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (r = 0; r < 11; r++)
      rd_chk(r * 4, 32'h0);
    wr(32'h40, 32'hff);
    rd_chk(32'h40, 32'h0);
    for (r = 0; r < 8; r++)
    begin
      rm[r] = 8'(8'h13 * r);
      wr(r * 4, {24'h0, rm[r]});
    end
    for (r = 0; r < 8; r++)
      rd_chk(r * 4, {24'h0, rm[r]});
    for (op = 0; op < 6; op++)
      for (r = 0; r < 8; r++)
      begin
        wr(32'h20, 32'h1d);
        run({8'h60, opc[op], 3'(r)}, 8);
        rd_chk(32'h20, {24'h0, exp_flags(op, rm[1], rm[r], 8'h1d)});
        rd_chk(r * 4, {24'h0, rm[r]});
        rd_chk(32'h04, {24'h0, rm[1]});
      end
    wr(32'h20, 32'h0);
    run(16'h60ea, 8);
    fl = exp_flags(0, rm[1], rm[2], 8'h00);
    rd_chk(32'h20, {24'h0, fl});
    wr(32'h24, 32'h60f9);
    repeat (10) @(posedge hclk);
    rd_chk(32'h28, 32'h4);
    rd_chk(32'h20, {24'h0, fl & 8'hdf});
    run(16'h60f9, 8);
    rd_chk(32'h20, {24'h0, exp_flags(2, rm[1], rm[1], fl & 8'hdf)});
    wr(32'h20, 32'h0);
    wr(32'h24, 32'h6000);
    repeat (10) @(posedge hclk);
    rd_chk(32'h28, 32'h2);
    wr(32'h24, 32'h70c0);
    repeat (10) @(posedge hclk);
    rd_chk(32'h28, 32'h2);
    rm = '{8'h00, 8'h88, 8'h12, 8'h34, 8'h40, 8'hff, 8'h42, 8'h00};
    for (r = 0; r < 8; r++)
      wr(r * 4, {24'h0, rm[r]});
    for (sel = 1; sel < 8; sel++)
    begin
      s = (sel == 1) ? 2 : ((sel % 2 == 1) ? 6 : 4);
      pr = {rm[s], rm[s + 1]};
      wr(32'h20, 32'h0c);
      run({8'h70, 5'h18, 3'(sel)}, 11);
      chk({16'h0, mem_addr}, {16'h0, pr});
      v = mem_f(pr);
      sum = {1'b0, rm[1]} + {1'b0, v};
      nb = {1'b0, rm[1][3:0]} + {1'b0, v[3:0]};
      fl = {1'b0, sum[7:0] == 8'h00, 1'b0, nb[4], 3'b000, sum[8]};
      rm[1] = sum[7:0];
      if (sel >= 4)
        {rm[s], rm[s + 1]} = (sel < 6) ? pr + 16'h1 : pr - 16'h1;
      rd_chk(32'h20, {24'h0, fl});
      rd_chk(32'h04, {24'h0, rm[1]});
      rd_chk(s * 4, {24'h0, rm[s]});
      rd_chk(s * 4 + 4, {24'h0, rm[s + 1]});
    end
    chk(rd_pulses, 32'h7);
    give_verdict();
  end
endmodule
